//--- common/gpp_pkg.sv
// Constants, register map and state encodings for the general purpose port block
package gpp_pkg;

  // ==========================================================================
  // Register offsets (byte addresses, one aligned word each)
  localparam logic [11:0] GPP_A_DATA_OFS = 12'h000;
  localparam logic [11:0] GPP_A_DIR_OFS = 12'h004;
  localparam logic [11:0] GPP_A_PULL_OFS = 12'h008;
  localparam logic [11:0] GPP_A_LATCH_OFS = 12'h00c;
  localparam logic [11:0] GPP_B_DATA_OFS = 12'h010;
  localparam logic [11:0] GPP_B_DIR_OFS = 12'h014;
  localparam logic [11:0] GPP_B_LATCH_OFS = 12'h01c;
  localparam logic [11:0] GPP_C_DATA_OFS = 12'h020;
  localparam logic [11:0] GPP_C_DIR_OFS = 12'h024;
  localparam logic [11:0] GPP_C_PULL_OFS = 12'h028;
  localparam logic [11:0] GPP_C_LATCH_OFS = 12'h02c;
  localparam logic [11:0] GPP_STBY_OFS = 12'h030;

  // ==========================================================================
  // Implemented bit masks per port
  localparam logic [7:0] GPP_A_MASK = 8'h1c;
  localparam logic [7:0] GPP_B_MASK = 8'h07;
  localparam logic [7:0] GPP_C_MASK = 8'h06;
  localparam logic [7:0] GPP_NO_PULL = 8'h00;

  // ==========================================================================
  // Reset values
  localparam logic [7:0] GPP_DATA_RST = 8'h00;
  localparam logic [7:0] GPP_DIR_RST = 8'h00;
  localparam logic [7:0] GPP_PULL_RST = 8'h00;
  localparam logic GPP_FLOAT_RST = 1'b0;

  // ==========================================================================
  // Standby control field and states
  localparam int GPP_FLOAT_BIT = 0;

  typedef enum logic [2:0] {
    GPP_ST_RUN = 3'b001,
    GPP_ST_FLOAT = 3'b010,
    GPP_ST_HOLD = 3'b100
  } gpp_stby_e;

endpackage : gpp_pkg

//--- core/gpp_standby_ctl.sv
// Standby pin-state sequencer: chooses float or hold on entry to stop or watch
module gpp_standby_ctl
  import gpp_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic standby_req,
  input wire logic standby_pin_float_bit,
  output logic pins_float,
  output logic pins_hold
);

  gpp_stby_e state_r;
  gpp_stby_e state_nxt;

  // The float bit is sampled only on entry, so a late change cannot glitch pins
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      GPP_ST_RUN: begin
        if (standby_req) begin
          state_nxt = standby_pin_float_bit ? GPP_ST_FLOAT : GPP_ST_HOLD;
        end
      end
      GPP_ST_FLOAT: begin
        if (!standby_req) begin
          state_nxt = GPP_ST_RUN;
        end
      end
      GPP_ST_HOLD: begin
        if (!standby_req) begin
          state_nxt = GPP_ST_RUN;
        end
      end
      default: begin
        state_nxt = GPP_ST_RUN;
      end
    endcase
  end

  // State register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_r <= GPP_ST_RUN;
    end else begin
      state_r <= state_nxt;
    end
  end

  assign pins_float = (state_r == GPP_ST_FLOAT);
  assign pins_hold = (state_r == GPP_ST_HOLD);

endmodule : gpp_standby_ctl

//--- core/gpp_port_pad.sv
// Per-port pin logic: drive, open-drain release, pull-up, input blocking, read mux
module gpp_port_pad
  import gpp_pkg::*;
#(
  parameter int W = 8,
  parameter logic [7:0] IMPL = 8'hff,
  parameter logic [7:0] OD = 8'h00
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [W-1:0] data,
  input wire logic [W-1:0] dir,
  input wire logic [W-1:0] pull,
  input wire logic pins_float,
  input wire logic pins_hold,
  input wire logic [W-1:0] periph_oe,
  input wire logic [W-1:0] periph_out,
  input wire logic [W-1:0] pad_in,
  output logic [W-1:0] pad_out,
  output logic [W-1:0] pad_oe,
  output logic [W-1:0] pullup_en,
  output logic [W-1:0] pin_level,
  output logic [W-1:0] port_read
);

  genvar i;
  generate
    for (i = 0; i < W; i++) begin : g_bit
      logic oe_nxt;
      logic out_nxt;
      logic pu_nxt;

      // Peripheral output wins over the port; open-drain bits only ever pull low
      always_comb begin
        if (periph_oe[i]) begin
          out_nxt = periph_out[i];
          oe_nxt = IMPL[i] & (!OD[i] | !periph_out[i]);
        end else begin
          out_nxt = data[i];
          oe_nxt = IMPL[i] & dir[i] & (!OD[i] | !data[i]);
        end
        pu_nxt = IMPL[i] & pull[i] & !(oe_nxt & !out_nxt);
      end

      // Registered pad controls; float clears, hold freezes
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          pad_out[i] <= 1'b0;
          pad_oe[i] <= 1'b0;
          pullup_en[i] <= 1'b0;
        end else if (pins_float) begin
          pad_out[i] <= 1'b0;
          pad_oe[i] <= 1'b0;
          pullup_en[i] <= 1'b0;
        end else if (!pins_hold) begin
          pad_out[i] <= out_nxt;
          pad_oe[i] <= oe_nxt;
          pullup_en[i] <= pu_nxt;
        end
      end

      // Input path blocked low while floating to avoid leakage from open inputs
      assign pin_level[i] = IMPL[i] & pad_in[i] & !pins_float;

      // Latch for plain outputs, pin level for inputs and peripheral pins
      assign port_read[i] = (dir[i] & !periph_oe[i]) ? data[i] : pin_level[i];
    end
  endgenerate

endmodule : gpp_port_pad

//--- core/gpp_top.sv
// General purpose port block: APB register file, three ports and standby handling
//
// Added by the designer: the APB register port and the register addresses.
module gpp_top
  import gpp_pkg::*;
#(
  parameter logic [7:0] A_OD = 8'h00,
  parameter logic [7:0] B_OD = 8'h04,
  parameter logic [7:0] C_OD = 8'h00
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic standby_req,
  output logic pins_float,
  input wire logic [7:0] port_a_periph_oe,
  input wire logic [7:0] port_a_periph_out,
  input wire logic [7:0] port_a_pad_in,
  output logic [7:0] port_a_pad_out,
  output logic [7:0] port_a_pad_oe,
  output logic [7:0] port_a_pullup_en,
  output logic [7:0] port_a_pin_level,
  input wire logic [7:0] port_b_periph_oe,
  input wire logic [7:0] port_b_periph_out,
  input wire logic [7:0] port_b_pad_in,
  output logic [7:0] port_b_pad_out,
  output logic [7:0] port_b_pad_oe,
  output logic [7:0] port_b_pin_level,
  input wire logic [7:0] port_c_periph_oe,
  input wire logic [7:0] port_c_periph_out,
  input wire logic [7:0] port_c_pad_in,
  output logic [7:0] port_c_pad_out,
  output logic [7:0] port_c_pad_oe,
  output logic [7:0] port_c_pullup_en,
  output logic [7:0] port_c_pin_level
);

  // ==========================================================================
  // Register storage
  logic [7:0] port_a_data_latch_r;
  logic [7:0] port_a_direction_r;
  logic [7:0] port_a_pullup_enable_r;
  logic [7:0] port_b_data_latch_r;
  logic [7:0] port_b_direction_r;
  logic [7:0] port_c_data_latch_r;
  logic [7:0] port_c_direction_r;
  logic [7:0] port_c_pullup_enable_r;
  logic standby_pin_float_bit_r;
  logic [31:0] prdata_r;
  logic [31:0] rd_nxt;

  logic pins_hold;
  logic addr_hit;
  logic wr_en;
  logic rd_setup;
  logic [7:0] wbyte;
  logic [7:0] port_a_read;
  logic [7:0] port_b_read;
  logic [7:0] port_c_read;

  // ==========================================================================
  // APB slave: zero wait states, read data sampled in the setup cycle, write data in the access cycle
  assign pready = 1'b1;
  assign wr_en = psel & penable & pwrite;
  assign rd_setup = psel & !penable & !pwrite;
  assign wbyte = pwdata[7:0];
  assign prdata = prdata_r;

  // Address decode for the error response
  always_comb begin
    case (paddr)
      GPP_A_DATA_OFS, GPP_A_DIR_OFS, GPP_A_PULL_OFS, GPP_A_LATCH_OFS: addr_hit = 1'b1;
      GPP_B_DATA_OFS, GPP_B_DIR_OFS, GPP_B_LATCH_OFS: addr_hit = 1'b1;
      GPP_C_DATA_OFS, GPP_C_DIR_OFS, GPP_C_PULL_OFS, GPP_C_LATCH_OFS: addr_hit = 1'b1;
      GPP_STBY_OFS: addr_hit = 1'b1;
      default: addr_hit = 1'b0;
    endcase
  end

  // Unmapped addresses answer with an error and have no effect
  assign pslverr = psel & penable & !addr_hit;

  // ==========================================================================
  // Port A registers; writes are masked so unimplemented bits stay zero
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      port_a_data_latch_r <= GPP_DATA_RST;
      port_a_direction_r <= GPP_DIR_RST;
      port_a_pullup_enable_r <= GPP_PULL_RST;
    end else if (wr_en) begin
      if (paddr == GPP_A_DATA_OFS) begin
        port_a_data_latch_r <= wbyte & GPP_A_MASK;
      end
      if (paddr == GPP_A_DIR_OFS) begin
        port_a_direction_r <= wbyte & GPP_A_MASK;
      end
      if (paddr == GPP_A_PULL_OFS) begin
        port_a_pullup_enable_r <= wbyte & GPP_A_MASK;
      end
    end
  end

  // ==========================================================================
  // Port B registers; this port carries no pull-up
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      port_b_data_latch_r <= GPP_DATA_RST;
      port_b_direction_r <= GPP_DIR_RST;
    end else if (wr_en) begin
      if (paddr == GPP_B_DATA_OFS) begin
        port_b_data_latch_r <= wbyte & GPP_B_MASK;
      end
      if (paddr == GPP_B_DIR_OFS) begin
        port_b_direction_r <= wbyte & GPP_B_MASK;
      end
    end
  end

  // ==========================================================================
  // Port C registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      port_c_data_latch_r <= GPP_DATA_RST;
      port_c_direction_r <= GPP_DIR_RST;
      port_c_pullup_enable_r <= GPP_PULL_RST;
    end else if (wr_en) begin
      if (paddr == GPP_C_DATA_OFS) begin
        port_c_data_latch_r <= wbyte & GPP_C_MASK;
      end
      if (paddr == GPP_C_DIR_OFS) begin
        port_c_direction_r <= wbyte & GPP_C_MASK;
      end
      if (paddr == GPP_C_PULL_OFS) begin
        port_c_pullup_enable_r <= wbyte & GPP_C_MASK;
      end
    end
  end

  // ==========================================================================
  // Standby control: only the float selection bit is implemented
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      standby_pin_float_bit_r <= GPP_FLOAT_RST;
    end else if (wr_en && paddr == GPP_STBY_OFS) begin
      standby_pin_float_bit_r <= pwdata[GPP_FLOAT_BIT];
    end
  end

  gpp_standby_ctl u_stby (
    .pclk(pclk),
    .presetn(presetn),
    .standby_req(standby_req),
    .standby_pin_float_bit(standby_pin_float_bit_r),
    .pins_float(pins_float),
    .pins_hold(pins_hold)
  );

  // ==========================================================================
  // Pin logic per port
  gpp_port_pad #(.W(8), .IMPL(GPP_A_MASK), .OD(A_OD)) u_pad_a (
    .pclk(pclk),
    .presetn(presetn),
    .data(port_a_data_latch_r),
    .dir(port_a_direction_r),
    .pull(port_a_pullup_enable_r),
    .pins_float(pins_float),
    .pins_hold(pins_hold),
    .periph_oe(port_a_periph_oe),
    .periph_out(port_a_periph_out),
    .pad_in(port_a_pad_in),
    .pad_out(port_a_pad_out),
    .pad_oe(port_a_pad_oe),
    .pullup_en(port_a_pullup_en),
    .pin_level(port_a_pin_level),
    .port_read(port_a_read)
  );

  gpp_port_pad #(.W(8), .IMPL(GPP_B_MASK), .OD(B_OD)) u_pad_b (
    .pclk(pclk),
    .presetn(presetn),
    .data(port_b_data_latch_r),
    .dir(port_b_direction_r),
    .pull(GPP_NO_PULL),
    .pins_float(pins_float),
    .pins_hold(pins_hold),
    .periph_oe(port_b_periph_oe),
    .periph_out(port_b_periph_out),
    .pad_in(port_b_pad_in),
    .pad_out(port_b_pad_out),
    .pad_oe(port_b_pad_oe),
    .pullup_en(),
    .pin_level(port_b_pin_level),
    .port_read(port_b_read)
  );

  gpp_port_pad #(.W(8), .IMPL(GPP_C_MASK), .OD(C_OD)) u_pad_c (
    .pclk(pclk),
    .presetn(presetn),
    .data(port_c_data_latch_r),
    .dir(port_c_direction_r),
    .pull(port_c_pullup_enable_r),
    .pins_float(pins_float),
    .pins_hold(pins_hold),
    .periph_oe(port_c_periph_oe),
    .periph_out(port_c_periph_out),
    .pad_in(port_c_pad_in),
    .pad_out(port_c_pad_out),
    .pad_oe(port_c_pad_oe),
    .pullup_en(port_c_pullup_en),
    .pin_level(port_c_pin_level),
    .port_read(port_c_read)
  );

  // ==========================================================================
  // Read mux: data offsets give the mixed view, alias offsets the raw latch
  always_comb begin
    rd_nxt = 32'h0000_0000;
    case (paddr)
      GPP_A_DATA_OFS: rd_nxt[7:0] = port_a_read;
      GPP_A_DIR_OFS: rd_nxt[7:0] = port_a_direction_r;
      GPP_A_PULL_OFS: rd_nxt[7:0] = port_a_pullup_enable_r;
      GPP_A_LATCH_OFS: rd_nxt[7:0] = port_a_data_latch_r;
      GPP_B_DATA_OFS: rd_nxt[7:0] = port_b_read;
      GPP_B_DIR_OFS: rd_nxt[7:0] = port_b_direction_r;
      GPP_B_LATCH_OFS: rd_nxt[7:0] = port_b_data_latch_r;
      GPP_C_DATA_OFS: rd_nxt[7:0] = port_c_read;
      GPP_C_DIR_OFS: rd_nxt[7:0] = port_c_direction_r;
      GPP_C_PULL_OFS: rd_nxt[7:0] = port_c_pullup_enable_r;
      GPP_C_LATCH_OFS: rd_nxt[7:0] = port_c_data_latch_r;
      GPP_STBY_OFS: rd_nxt[GPP_FLOAT_BIT] = standby_pin_float_bit_r;
      default: rd_nxt = 32'h0000_0000;
    endcase
  end

  // Read data captured in setup so it is stable for the whole access phase
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_r <= 32'h0000_0000;
    end else if (rd_setup) begin
      prdata_r <= rd_nxt;
    end
  end

  // ==========================================================================
  // Checks
  dir_reset_a: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(presetn) |-> (port_a_direction_r == 8'h00 && port_b_direction_r == 8'h00 &&
      port_c_direction_r == 8'h00))
    else $error("direction not cleared by reset");

  latch_write_a: assert property (@(posedge pclk) disable iff (!presetn)
    (wr_en && paddr == GPP_A_DATA_OFS) |=> (port_a_data_latch_r == ($past(wbyte) & GPP_A_MASK)))
    else $error("port a latch did not take write");

  out_drive_a: assert property (@(posedge pclk) disable iff (!presetn)
    (!pins_float && !pins_hold && port_a_periph_oe == 8'h00) |=>
      (port_a_pad_oe == ($past(port_a_direction_r) & GPP_A_MASK & ~(A_OD & $past(port_a_data_latch_r)))))
    else $error("port a drive enable wrong");

  float_hiz_a: assert property (@(posedge pclk) disable iff (!presetn)
    (pins_float && $past(pins_float)) |-> (port_a_pad_oe == 8'h00 && port_b_pad_oe == 8'h00 &&
      port_c_pad_oe == 8'h00 && port_a_pin_level == 8'h00 && port_b_pin_level == 8'h00))
    else $error("pins not floated in standby");

  hold_keep_a: assert property (@(posedge pclk) disable iff (!presetn)
    (pins_hold && $past(pins_hold)) |-> ($stable(port_b_pad_oe) && $stable(port_b_pad_out)))
    else $error("pins changed in hold standby");

  latch_read_a: assert property (@(posedge pclk) disable iff (!presetn)
    (rd_setup && paddr == GPP_A_LATCH_OFS) |=> (prdata == {24'h000000, $past(port_a_data_latch_r)}))
    else $error("latch alias read did not return latch");

  pull_low_a: assert property (@(posedge pclk) disable iff (!presetn)
    ((port_a_pullup_en & port_a_pad_oe & ~port_a_pad_out) == 8'h00) &&
      ((port_c_pullup_en & port_c_pad_oe & ~port_c_pad_out) == 8'h00))
    else $error("pull-up on while driving low");

  od_release_a: assert property (@(posedge pclk) disable iff (!presetn)
    ((port_b_pad_oe & port_b_pad_out & B_OD) == 8'h00))
    else $error("open-drain pin driven high");

  unimpl_zero_a: assert property (@(posedge pclk) disable iff (!presetn)
    ((port_a_direction_r & ~GPP_A_MASK) == 8'h00 && (port_b_data_latch_r & ~GPP_B_MASK) == 8'h00 &&
      (port_c_pullup_enable_r & ~GPP_C_MASK) == 8'h00))
    else $error("unimplemented bit set");

  unmapped_err_a: assert property (@(posedge pclk) disable iff (!presetn)
    (psel && penable && !addr_hit) |-> (pslverr && pready))
    else $error("unmapped access not refused");

endmodule : gpp_top

//--- tb/gpp_pin_model.sv
// Pin side model: resolves pad drive, outside driver and pull-up into the sampled level
module gpp_pin_model (
  input wire logic pclk,
  input wire logic [7:0] pad_out,
  input wire logic [7:0] pad_oe,
  input wire logic [7:0] pullup_en,
  input wire logic [7:0] ext_en,
  input wire logic [7:0] ext_val,
  output logic [7:0] pad_in
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] last_r = 8'h00;

  // ==========================================================================
  // Pin resolution
  // Pad drive wins, then the outside driver, then the pull-up; a floating
  // pin toggles so that a lucky settled value never passes for a match
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      if (pad_oe[i]) begin
        pad_in[i] = pad_out[i];
      end else if (ext_en[i]) begin
        pad_in[i] = ext_val[i];
      end else if (pullup_en[i]) begin
        pad_in[i] = 1'b1;
      end else begin
        pad_in[i] = ~last_r[i];
      end
    end
  end

  // Last level, kept only for the floating case
  always @(posedge pclk) begin
    last_r <= pad_in;
  end
endmodule : gpp_pin_model

//--- tb/general_purpose_io_ports_tb.sv
// Self-checking bench for the general purpose port block
module general_purpose_io_ports_tb
  import gpp_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, standby_req = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata;
  logic pready, pslverr, pins_float, last_err;
  logic [7:0] a_poe = 8'h00, a_pout = 8'h00, b_poe = 8'h00, b_pout = 8'h00;
  logic [7:0] c_poe = 8'h00, c_pout = 8'h00;
  logic [7:0] a_een = 8'h00, a_ev = 8'h00, b_een = 8'h00, b_ev = 8'h00, c_een = 8'h00, c_ev = 8'h00;
  logic [7:0] a_in, a_out, a_oe, a_pu, a_lvl, b_in, b_out, b_oe, b_lvl, c_in, c_out, c_oe, c_pu, c_lvl;
  int num_errors = 0;
  int num_checks = 0;

  // ==========================================================================
  // Clock, device and pins
  always #2.5 pclk = ~pclk;

  gpp_top DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .standby_req(standby_req), .pins_float(pins_float),
    .port_a_periph_oe(a_poe), .port_a_periph_out(a_pout), .port_a_pad_in(a_in), .port_a_pad_out(a_out),
    .port_a_pad_oe(a_oe), .port_a_pullup_en(a_pu), .port_a_pin_level(a_lvl),
    .port_b_periph_oe(b_poe), .port_b_periph_out(b_pout), .port_b_pad_in(b_in), .port_b_pad_out(b_out),
    .port_b_pad_oe(b_oe), .port_b_pin_level(b_lvl),
    .port_c_periph_oe(c_poe), .port_c_periph_out(c_pout), .port_c_pad_in(c_in), .port_c_pad_out(c_out),
    .port_c_pad_oe(c_oe), .port_c_pullup_en(c_pu), .port_c_pin_level(c_lvl));

  gpp_pin_model pins_a (.pclk(pclk), .pad_out(a_out), .pad_oe(a_oe), .pullup_en(a_pu),
    .ext_en(a_een), .ext_val(a_ev), .pad_in(a_in));
  // Second port has no pull-up, so its pins float when nobody drives them
  gpp_pin_model pins_b (.pclk(pclk), .pad_out(b_out), .pad_oe(b_oe), .pullup_en(8'h00),
    .ext_en(b_een), .ext_val(b_ev), .pad_in(b_in));
  gpp_pin_model pins_c (.pclk(pclk), .pad_out(c_out), .pad_oe(c_oe), .pullup_en(c_pu),
    .ext_en(c_een), .ext_val(c_ev), .pad_in(c_in));

  // ==========================================================================
  // Shared tasks
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // One transfer; request held until pready is seen high at a rising edge
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d, output logic [31:0] q);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) num_errors++;
    q = prdata;
    last_err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    logic [31:0] q;
    apb(1'b1, a, {24'h0, d}, q);
  endtask : wr

  task automatic rdc(input logic [11:0] a, input logic [7:0] exp);
    logic [31:0] q;
    apb(1'b0, a, 32'h0, q);
    chk(q, {24'h0, exp});
  endtask : rdc

  // Pad outputs follow one edge later; sample away from the edge
  task automatic settle(input int n);
    repeat (n) @(posedge pclk);
    @(negedge pclk);
  endtask : settle

  // ==========================================================================
  // Scenarios
  task automatic t_reset();
    rdc(GPP_A_DIR_OFS, 8'h00);
    rdc(GPP_B_DIR_OFS, 8'h00);
    rdc(GPP_C_DIR_OFS, 8'h00);
    chk({a_oe, b_oe, c_oe}, 24'h0);
  endtask : t_reset

  task automatic t_output();
    @(posedge pclk);
    a_een <= 8'hff;
    a_ev <= 8'h00;
    wr(GPP_A_DATA_OFS, 8'hff);
    wr(GPP_A_DIR_OFS, 8'hff);
    settle(2);
    chk({a_oe, a_out}, 16'h1c1c);
    chk(a_lvl, 8'h1c);
    rdc(GPP_A_DATA_OFS, 8'h1c);
    rdc(GPP_A_DIR_OFS, 8'h1c);
  endtask : t_output

  task automatic t_input();
    @(posedge pclk);
    a_ev <= 8'h08;
    wr(GPP_A_DIR_OFS, 8'h00);
    wr(GPP_A_DATA_OFS, 8'h14);
    settle(2);
    chk(a_oe, 8'h00);
    chk(a_lvl, 8'h08);
    rdc(GPP_A_DATA_OFS, 8'h08);
    rdc(GPP_A_LATCH_OFS, 8'h14);
  endtask : t_input

  task automatic t_periph();
    @(posedge pclk);
    a_poe <= 8'h04;
    a_pout <= 8'h00;
    settle(2);
    // Bit4 still shows its latch level on the undriven pad output
    chk({a_oe, a_out}, 16'h0410);
    rdc(GPP_A_DATA_OFS, 8'h08);
    rdc(GPP_A_LATCH_OFS, 8'h14);
    // Peripheral output off before the pin returns to port use
    @(posedge pclk);
    a_poe <= 8'h00;
  endtask : t_periph

  task automatic t_pullup();
    @(posedge pclk);
    a_een <= 8'h00;
    wr(GPP_A_DATA_OFS, 8'h00);
    wr(GPP_A_DIR_OFS, 8'h04);
    wr(GPP_A_PULL_OFS, 8'hff);
    settle(2);
    chk(a_pu, 8'h18);
    rdc(GPP_A_PULL_OFS, 8'h1c);
    wr(GPP_A_DATA_OFS, 8'h04);
    settle(2);
    chk(a_pu, 8'h1c);
    wr(GPP_A_PULL_OFS, 8'h00);
    settle(2);
    chk(a_pu, 8'h00);
    wr(GPP_A_PULL_OFS, 8'h1c);
  endtask : t_pullup

  task automatic t_float();
    wr(GPP_STBY_OFS, 8'h01);
    @(posedge pclk);
    a_een <= 8'hff;
    a_ev <= 8'hff;
    standby_req <= 1'b1;
    settle(3);
    chk({pins_float, a_oe, a_pu, a_lvl}, 25'h1000000);
    @(posedge pclk);
    standby_req <= 1'b0;
    settle(3);
    chk({pins_float, a_oe}, 9'h004);
  endtask : t_float

  task automatic t_hold();
    wr(GPP_STBY_OFS, 8'h00);
    @(posedge pclk);
    standby_req <= 1'b1;
    settle(3);
    chk({pins_float, a_oe, a_out, a_pu}, 25'h004041c);
    wr(GPP_A_DATA_OFS, 8'h00);
    settle(2);
    chk(a_out, 8'h04);
    @(posedge pclk);
    standby_req <= 1'b0;
    settle(3);
    chk(a_out, 8'h00);
  endtask : t_hold

  // Second port: bit2 is open drain, there is no pull-up register
  task automatic t_port_b();
    @(posedge pclk);
    b_een <= 8'hff;
    b_ev <= 8'h00;
    wr(GPP_B_DIR_OFS, 8'hff);
    wr(GPP_B_DATA_OFS, 8'hff);
    settle(2);
    chk(b_oe, 8'h03);
    chk(b_lvl, 8'h03);
    rdc(GPP_B_DATA_OFS, 8'h07);
    wr(GPP_B_DATA_OFS, 8'h00);
    settle(2);
    chk({b_oe, b_out}, 16'h0700);
    wr(12'h018, 8'hff);
    chk(last_err, 1'b1);
    rdc(12'h018, 8'h00);
    rdc(GPP_B_LATCH_OFS, 8'h00);
  endtask : t_port_b

  task automatic t_port_c();
    wr(GPP_C_DATA_OFS, 8'hff);
    wr(GPP_C_DIR_OFS, 8'hff);
    wr(GPP_C_PULL_OFS, 8'hff);
    rdc(GPP_C_DATA_OFS, 8'h06);
    rdc(GPP_C_DIR_OFS, 8'h06);
    rdc(GPP_C_PULL_OFS, 8'h06);
    settle(2);
    chk({c_oe, c_out, c_pu}, 24'h060606);
    chk(c_lvl, 8'h06);
    // Outside driver pulls low; it overrides the pull-up once the pad lets go
    @(posedge pclk);
    c_een <= 8'hff;
    c_ev <= 8'h00;
    wr(GPP_C_DIR_OFS, 8'h00);
    settle(2);
    chk({c_oe, c_lvl}, 16'h0000);
    rdc(GPP_C_DATA_OFS, 8'h00);
    rdc(GPP_C_LATCH_OFS, 8'h06);
  endtask : t_port_c

  // ==========================================================================
  // Verdict, watchdog and main sequence
  task automatic summarize();
    if (num_errors == 0 && num_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : summarize

  // Whole sequence needs well under 500 cycles; allow ten times that
  initial begin
    #25000;
    num_errors++;
    summarize();
  end

  initial begin
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_output();
    t_input();
    t_periph();
    t_pullup();
    t_float();
    t_hold();
    t_port_b();
    t_port_c();
    summarize();
  end
endmodule : general_purpose_io_ports_tb
